// ### rtl/sch_pkg.sv
package sch_pkg;

  // ****************************************************************
  // command characters (ascii)
  // ****************************************************************
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;

  // ****************************************************************
  // register map (word index on the plain register port)
  // ****************************************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam logic [3:0] REG_FIRST_CH = 4'h4;
  localparam logic [3:0] REG_LAST_CH = 4'h5;
  localparam logic [3:0] REG_VIEW = 4'h6;
  localparam logic [3:0] REG_ERRORS = 4'h7;

  // status / mask bit positions
  localparam int ST_BEEP = 0;
  localparam int ST_CLEAR = 1;
  localparam int ST_DISP = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_W = 4;

  // ****************************************************************
  // reset values and settings
  // ****************************************************************
  localparam logic [9:0] FIRST_CH_RST = 10'h000;
  localparam logic [9:0] LAST_CH_RST = 10'h3e7;
  localparam logic [1:0] TRIG_INTERNAL = 2'h1;
  localparam logic [1:0] TRIG_RST = 2'h1;
  localparam logic DISP_ON_RST = 1'b1;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int BEEP_US = 100;
  localparam int BEEP_CYC = (BEEP_US * 1000) / CLK_NS;
  localparam int CLR_PULSE_CYC = 1;

  typedef enum logic [4:0] {
    SCH_IDLE = 5'b00001,
    SCH_CHAR2 = 5'b00010,
    SCH_ARG = 5'b00100,
    SCH_EXEC = 5'b01000,
    SCH_BUSY = 5'b10000
  } sch_state_e;

  typedef enum logic [2:0] {
    SCH_OP_NONE = 3'h0,
    SCH_OP_BEEP = 3'h1,
    SCH_OP_CLEAR = 3'h2,
    SCH_OP_DISP = 3'h3,
    SCH_OP_VIEW = 3'h4
  } sch_op_e;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic serial;
  } sch_char_s;

  typedef struct packed {
    logic abort_exec;
    logic stop_tx;
    logic open_channels;
    logic init_plugins;
    logic clear_errors;
  } sch_clear_s;

endpackage

// ### rtl/sch_beeper.sv
`timescale 1ns/1ps
// ****************************************************************
// single beep timer
// ****************************************************************
module sch_beeper #(
  parameter int BEEP_CYCLES = sch_pkg::BEEP_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control
  input wire logic start_in,
  output logic busy_out,
  output logic sounder_out
);
  typedef struct packed {
    logic [23:0] cnt;
    logic on;
  } sch_beep_s;

  sch_beep_s st_ff;
  sch_beep_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.on) begin
      if (st_ff.cnt == 24'h000001) begin
        nxt_st.on = 1'b0;
      end
      nxt_st.cnt = st_ff.cnt - 24'h000001;
    end else if (start_in) begin
      nxt_st.on = 1'b1;
      nxt_st.cnt = 24'(BEEP_CYCLES);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy_out = st_ff.on;
  assign sounder_out = st_ff.on;
endmodule // sch_beeper

// ### rtl/sch_system_command_handler.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - beep command drives the sounder for exactly one beep.
// - partial clear is taken from the serial link or the panel reset key; no power-on reset.
// - clear aborts executing commands and stops transmission to controller.
// - clear opens all channels and initialises all plug-in assemblies.
// - clear zeroes interrupt mask and status register, then sets the status clear bit.
// - clear sets voltmeter trigger to the internal setting.
// - clear sets first scan channel 000 and last 999.
// - clear keeps voltmeter format and reading storage buffer.
// - clear keeps local/remote mode and command input buffer.
// - clear erases recorded system errors; controller sends it alone.
// - front panel clear command is rejected; only the reset key clears locally.
// - display-off freezes numeric display and blanks channel lamps only.
// - while off, only view values update the numeric display.
// - display-on restores normal numeric and channel updating.
// - display is enabled after reset.
module sch_system_command_handler #(
  parameter int BEEP_CYCLES = sch_pkg::BEEP_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // command characters
  input wire sch_pkg::sch_char_s cmd_char_in,
  output logic cmd_ready_out,
  // front panel
  input wire logic panel_reset_key_in,
  input wire logic [23:0] normal_value_in,
  input wire logic [9:0] normal_channel_in,
  input wire logic [23:0] view_value_in,
  output logic [23:0] numeric_display_out,
  output logic [9:0] channel_lamps_out,
  output logic channel_lamps_en_out,
  output logic sounder_out,
  // system events
  input wire logic [sch_pkg::ST_W-1:0] ext_event_in,
  input wire logic sys_error_in,
  // clear actions
  output sch_pkg::sch_clear_s clear_out,
  output logic [1:0] trigger_src_out,
  output logic [9:0] first_ch_out,
  output logic [9:0] last_ch_out,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // interrupt
  output logic irq_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sch_pkg::sch_state_e fsm;
    sch_pkg::sch_op_e op;
    logic [7:0] arg;
    logic has_arg;
    logic from_serial;
    logic [sch_pkg::ST_W-1:0] status;
    logic [sch_pkg::ST_W-1:0] mask;
    logic disp_on;
    logic [23:0] view_val;
    logic [23:0] disp_val;
    logic [9:0] chan_val;
    logic [1:0] trig;
    logic [9:0] first_ch;
    logic [9:0] last_ch;
    logic [7:0] err_cnt;
    sch_pkg::sch_clear_s clr;
    logic beep_go;
    logic [31:0] rdata;
  } sch_st_s;

  sch_st_s st_ff;
  sch_st_s nxt_st;
  logic beep_busy;

  sch_beeper #(
    .BEEP_CYCLES(BEEP_CYCLES)
  ) u_beeper (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(st_ff.beep_go),
    .busy_out(beep_busy),
    .sounder_out(sounder_out)
  );

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= sch_pkg::CH_0) && (c <= sch_pkg::CH_9);
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic do_clear;
    logic [sch_pkg::ST_W-1:0] ev;
    do_clear = 1'b0;
    ev = ext_event_in;
    nxt_st = st_ff;
    nxt_st.beep_go = 1'b0;
    nxt_st.clr = '0;
    nxt_st.rdata = '0;

    // decoder
    case (st_ff.fsm)
      sch_pkg::SCH_IDLE: begin
        if (cmd_char_in.valid && cmd_char_in.data == sch_pkg::CH_S) begin
          nxt_st.fsm = sch_pkg::SCH_CHAR2;
          nxt_st.from_serial = cmd_char_in.serial;
        end
      end
      sch_pkg::SCH_CHAR2: begin
        if (cmd_char_in.valid) begin
          nxt_st.has_arg = 1'b0;
          nxt_st.fsm = sch_pkg::SCH_ARG;
          case (cmd_char_in.data)
            sch_pkg::CH_A: nxt_st.op = sch_pkg::SCH_OP_BEEP;
            sch_pkg::CH_C: nxt_st.op = sch_pkg::SCH_OP_CLEAR;
            sch_pkg::CH_D: nxt_st.op = sch_pkg::SCH_OP_DISP;
            sch_pkg::CH_V: nxt_st.op = sch_pkg::SCH_OP_VIEW;
            default: begin
              nxt_st.op = sch_pkg::SCH_OP_NONE;
              nxt_st.fsm = sch_pkg::SCH_IDLE;
              ev[sch_pkg::ST_REJECT] = 1'b1;
            end
          endcase
        end
      end
      sch_pkg::SCH_ARG: begin
        // optional digit; the next char, digit or not, ends the command
        if (cmd_char_in.valid) begin
          if (is_digit(cmd_char_in.data)) begin
            nxt_st.arg = cmd_char_in.data - sch_pkg::CH_0;
            nxt_st.has_arg = 1'b1;
          end
          nxt_st.fsm = sch_pkg::SCH_EXEC;
        end
      end
      sch_pkg::SCH_EXEC: begin
        nxt_st.fsm = sch_pkg::SCH_BUSY;
        case (st_ff.op)
          sch_pkg::SCH_OP_BEEP: begin
            nxt_st.beep_go = 1'b1;
            ev[sch_pkg::ST_BEEP] = 1'b1;
          end
          sch_pkg::SCH_OP_CLEAR: begin
            if (st_ff.from_serial) begin
              do_clear = 1'b1;
            end else begin
              ev[sch_pkg::ST_REJECT] = 1'b1;
            end
          end
          sch_pkg::SCH_OP_DISP: begin
            if (st_ff.has_arg && st_ff.arg == 8'h00) begin
              nxt_st.disp_on = 1'b0;
            end else if (st_ff.has_arg && st_ff.arg == 8'h01) begin
              nxt_st.disp_on = 1'b1;
            end else begin
              ev[sch_pkg::ST_REJECT] = 1'b1;
            end
            ev[sch_pkg::ST_DISP] = 1'b1;
          end
          sch_pkg::SCH_OP_VIEW: begin
            nxt_st.view_val = view_value_in;
            nxt_st.disp_val = view_value_in;
          end
          default: begin
            nxt_st.fsm = sch_pkg::SCH_IDLE;
          end
        endcase
      end
      sch_pkg::SCH_BUSY: begin
        // next command waits for the beep to finish
        if (!beep_busy && !st_ff.beep_go) begin
          nxt_st.fsm = sch_pkg::SCH_IDLE;
        end
      end
      default: begin
        nxt_st.fsm = sch_pkg::SCH_IDLE;
      end
    endcase

    if (panel_reset_key_in) begin
      do_clear = 1'b1;
    end

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        sch_pkg::REG_STATUS: begin
          nxt_st.status = st_ff.status & ~reg_wdata_in[sch_pkg::ST_W-1:0];
        end
        sch_pkg::REG_MASK: nxt_st.mask = reg_wdata_in[sch_pkg::ST_W-1:0];
        sch_pkg::REG_CTRL: nxt_st.disp_on = reg_wdata_in[0];
        default: begin
        end
      endcase
    end

    // display path; lamps go dark in the same cycle the display turns off
    if (nxt_st.disp_on) begin
      nxt_st.disp_val = normal_value_in;
      nxt_st.chan_val = normal_channel_in;
    end else begin
      nxt_st.chan_val = '0;
    end

    if (sys_error_in && st_ff.err_cnt != 8'hff) begin
      nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
    end

    // partial clear: mode, input buffer, format and storage untouched
    if (do_clear) begin
      nxt_st.fsm = sch_pkg::SCH_IDLE;
      nxt_st.op = sch_pkg::SCH_OP_NONE;
      nxt_st.beep_go = 1'b0;
      nxt_st.clr.abort_exec = 1'b1;
      nxt_st.clr.stop_tx = 1'b1;
      nxt_st.clr.open_channels = 1'b1;
      nxt_st.clr.init_plugins = 1'b1;
      nxt_st.clr.clear_errors = 1'b1;
      nxt_st.err_cnt = '0;
      nxt_st.mask = '0;
      nxt_st.status = '0;
      nxt_st.trig = sch_pkg::TRIG_INTERNAL;
      nxt_st.first_ch = sch_pkg::FIRST_CH_RST;
      nxt_st.last_ch = sch_pkg::LAST_CH_RST;
      nxt_st.status[sch_pkg::ST_CLEAR] = 1'b1;
    end else begin
      // set wins over write-one-to-clear
      nxt_st.status = nxt_st.status | ev;
    end

    // register reads
    if (reg_rd_in) begin
      case (reg_addr_in)
        sch_pkg::REG_STATUS: nxt_st.rdata = 32'(st_ff.status);
        sch_pkg::REG_MASK: nxt_st.rdata = 32'(st_ff.mask);
        sch_pkg::REG_CTRL: nxt_st.rdata = 32'(st_ff.disp_on);
        sch_pkg::REG_STATE: nxt_st.rdata = {27'h0, st_ff.fsm};
        sch_pkg::REG_FIRST_CH: nxt_st.rdata = 32'(st_ff.first_ch);
        sch_pkg::REG_LAST_CH: nxt_st.rdata = 32'(st_ff.last_ch);
        sch_pkg::REG_VIEW: nxt_st.rdata = 32'(st_ff.view_val);
        sch_pkg::REG_ERRORS: nxt_st.rdata = {22'h0, st_ff.trig, st_ff.err_cnt};
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
      st_ff.fsm <= sch_pkg::SCH_IDLE;
      st_ff.disp_on <= sch_pkg::DISP_ON_RST;
      st_ff.trig <= sch_pkg::TRIG_RST;
      st_ff.first_ch <= sch_pkg::FIRST_CH_RST;
      st_ff.last_ch <= sch_pkg::LAST_CH_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cmd_ready_out = (st_ff.fsm != sch_pkg::SCH_EXEC) && (st_ff.fsm != sch_pkg::SCH_BUSY);
  assign numeric_display_out = st_ff.disp_val;
  assign channel_lamps_out = st_ff.chan_val;
  assign channel_lamps_en_out = st_ff.disp_on;
  assign clear_out = st_ff.clr;
  assign trigger_src_out = st_ff.trig;
  assign first_ch_out = st_ff.first_ch;
  assign last_ch_out = st_ff.last_ch;
  assign reg_rdata_out = st_ff.rdata;
  assign irq_out = |(st_ff.status & st_ff.mask);

endmodule // sch_system_command_handler

// ### sim/sch_handler_props.sv
`timescale 1ns/1ps
module sch_handler_props #(
  parameter int BEEP_CYCLES = 5
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // watched signals
  input wire logic cmd_ready_out,
  input wire logic sounder_out,
  input wire sch_pkg::sch_clear_s clear_out,
  input wire logic [1:0] trigger_src_out,
  input wire logic [9:0] first_ch_out,
  input wire logic [9:0] last_ch_out,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic irq_out,
  input wire logic channel_lamps_en_out,
  input wire logic [9:0] channel_lamps_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ****************************************************************
  // beep length counter
  // ****************************************************************
  int beep_cnt_ff;
  always_ff @(posedge clk_in) begin
    beep_cnt_ff <= (srst_in || !sounder_out) ? 0 : beep_cnt_ff + 1;
  end
  a_beep_one_len: assert property ($fell(sounder_out) |-> beep_cnt_ff == BEEP_CYCLES)
    else $error("beep length wrong");
  a_clear_all_acts: assert property (clear_out.abort_exec |-> clear_out.stop_tx &&
    clear_out.open_channels && clear_out.init_plugins && clear_out.clear_errors)
    else $error("clear actions incomplete");
  a_clear_one_pulse: assert property (clear_out.abort_exec |=> !clear_out.abort_exec)
    else $error("clear pulse too long");
  a_clear_trig_int: assert property (clear_out.abort_exec |-> ##[0:1]
    trigger_src_out == sch_pkg::TRIG_INTERNAL)
    else $error("trigger not internal after clear");
  a_clear_scan_lim: assert property (clear_out.abort_exec |-> ##[0:1]
    (first_ch_out == 10'h000 && last_ch_out == 10'h3e7))
    else $error("scan limits wrong after clear");
  a_clear_irq_off: assert property (clear_out.abort_exec |-> ##[0:1] !irq_out)
    else $error("interrupt after clear");
  a_exec_not_ready: assert property ($rose(sounder_out) |-> !cmd_ready_out)
    else $error("ready during execute");
  a_lamps_blanked: assert property (!channel_lamps_en_out |-> channel_lamps_out == 10'h000)
    else $error("lamps lit while display off");
  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read cycle");
endmodule // sch_handler_props
bind sch_system_command_handler sch_handler_props #(.BEEP_CYCLES(BEEP_CYCLES)) sch_handler_props_i (
  .clk_in(clk_in), .srst_in(srst_in), .cmd_ready_out(cmd_ready_out),
  .sounder_out(sounder_out), .clear_out(clear_out), .trigger_src_out(trigger_src_out),
  .first_ch_out(first_ch_out), .last_ch_out(last_ch_out), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
  .channel_lamps_en_out(channel_lamps_en_out), .channel_lamps_out(channel_lamps_out));

// ### sim/sch_host_model.sv
`timescale 1ns/1ps
module sch_host_model (
  // clock
  input wire logic clk_in,
  // command link
  input wire logic cmd_ready_in,
  output sch_pkg::sch_char_s cmd_char_out
);
  initial cmd_char_out = '0;
  // one char, held until taken, then line shows inverse value
  task automatic send(input logic [7:0] c, input logic ser);
    @(posedge clk_in);
    cmd_char_out <= '{data: c, valid: 1'b1, serial: ser};
    @(posedge clk_in);
    while (!cmd_ready_in) @(posedge clk_in);
    cmd_char_out <= '{data: ~c, valid: 1'b0, serial: ~ser};
  endtask
  // whole command sent alone, never inside a string
  task automatic cmd3(input logic [7:0] a, input logic [7:0] b, input logic ser);
    send(sch_pkg::CH_S, ser);
    send(a, ser);
    send(b, ser);
  endtask
endmodule // sch_host_model

// ### sim/tb_system_command_handler.sv
`timescale 1ns/1ps
module tb_system_command_handler;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic key = 1'b0, rd = 1'b0, wr = 1'b0, serr = 1'b0, ready, snd, irq, len;
  logic [3:0] addr = 4'h0, ev = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [23:0] nval = 24'h111111, vval = 24'h123456, disp;
  logic [9:0] nch = 10'h155, lamps, fch, lch;
  logic [1:0] trig;
  sch_pkg::sch_char_s chr;
  sch_pkg::sch_clear_s clr;
  int mismatches = 0, cmp_count = 0;
  always #4 clk_in = ~clk_in;
  sch_host_model sch_host_model_i (.clk_in(clk_in), .cmd_ready_in(ready), .cmd_char_out(chr));
  sch_system_command_handler #(.BEEP_CYCLES(5)) sch_system_command_handler_i (
    .clk_in(clk_in), .srst_in(srst_in), .cmd_char_in(chr), .cmd_ready_out(ready),
    .panel_reset_key_in(key), .normal_value_in(nval), .normal_channel_in(nch),
    .view_value_in(vval), .numeric_display_out(disp), .channel_lamps_out(lamps),
    .channel_lamps_en_out(len), .sounder_out(snd), .ext_event_in(ev), .sys_error_in(serr),
    .clear_out(clr), .trigger_src_out(trig), .first_ch_out(fch), .last_ch_out(lch),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_in);
    {rd, addr} <= {1'b1, a};
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    d = rdata;
  endtask
  task automatic wait_clr(output logic seen);
    seen = 1'b0;
    repeat (20) begin
      @(posedge clk_in);
      if (clr.abort_exec === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    reg_rd(sch_pkg::REG_CTRL); chk(d & 32'h1, 32'h1);
    reg_rd(sch_pkg::REG_STATUS); chk(d, 32'h0);
    reg_rd(sch_pkg::REG_MASK); chk(d, 32'h0);
    chk(32'(trig), 32'(sch_pkg::TRIG_INTERNAL));
    chk({fch, lch}, {10'h000, 10'h3e7});
    reg_rd(4'h9); chk(d, 32'h0);
  endtask
  task automatic t_beep_clear();
    int n;
    logic s;
    n = 0;
    sch_host_model_i.cmd3(sch_pkg::CH_A, 8'h3b, 1'b1);
    repeat (20) if (snd !== 1'b1) @(posedge clk_in);
    while (snd === 1'b1 && n < 50) begin
      n++;
      @(posedge clk_in);
    end
    chk(n, 5);
    reg_wr(sch_pkg::REG_MASK, 32'hf);
    @(posedge clk_in); chk(irq, 1'b1);
    @(posedge clk_in); serr <= 1'b1; @(posedge clk_in); serr <= 1'b0;
    sch_host_model_i.cmd3(sch_pkg::CH_C, 8'h3b, 1'b1);
    wait_clr(s); chk(s, 1'b1);
    chk(irq, 1'b0);
    reg_rd(sch_pkg::REG_MASK); chk(d, 32'h0);
    reg_rd(sch_pkg::REG_STATUS); chk(d, 32'h1 << sch_pkg::ST_CLEAR);
    reg_rd(sch_pkg::REG_ERRORS); chk(d, 32'h100);
    chk({trig, fch, lch}, {sch_pkg::TRIG_INTERNAL, 10'h000, 10'h3e7});
  endtask
  task automatic t_refuse_panel();
    logic s;
    reg_wr(sch_pkg::REG_STATUS, 32'hf);
    sch_host_model_i.cmd3(sch_pkg::CH_C, 8'h3b, 1'b0);
    wait_clr(s); chk(s, 1'b0);
    reg_rd(sch_pkg::REG_STATUS); chk(d, 32'h1 << sch_pkg::ST_REJECT);
    reg_wr(sch_pkg::REG_STATUS, 32'hf);
    key <= 1'b1; @(posedge clk_in); key <= 1'b0;
    wait_clr(s); chk(s, 1'b1);
    reg_rd(sch_pkg::REG_STATUS); chk(d, 32'h1 << sch_pkg::ST_CLEAR);
    reg_wr(sch_pkg::REG_STATUS, 32'hf);
    sch_host_model_i.cmd3(8'h51, 8'h3b, 1'b1);
    repeat (4) @(posedge clk_in);
    reg_rd(sch_pkg::REG_STATUS); chk(d & 32'h8, 32'h8);
  endtask
  task automatic t_display();
    sch_host_model_i.cmd3(sch_pkg::CH_D, sch_pkg::CH_0, 1'b1);
    repeat (4) @(posedge clk_in);
    chk({len, lamps}, 11'h0);
    nval <= 24'h222222;
    repeat (4) @(posedge clk_in);
    chk(disp === 24'h222222, 1'b0);
    sch_host_model_i.cmd3(sch_pkg::CH_V, 8'h3b, 1'b1);
    repeat (4) @(posedge clk_in);
    chk(disp, vval);
    sch_host_model_i.cmd3(sch_pkg::CH_D, 8'h31, 1'b1);
    repeat (4) @(posedge clk_in);
    chk({len, disp}, {1'b1, 24'h222222});
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_beep_clear();
    t_refuse_panel();
    t_display();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end
endmodule // tb_system_command_handler
